// [ucc_pkg.sv]
// Package: register map, field positions and shared types for the command control block
package ucc_pkg;

  // Register byte offsets
  localparam logic [7:0] UCC_CMD_OFFSET = 8'h00;
  localparam logic [7:0] UCC_STS_OFFSET = 8'h04;
  localparam logic [7:0] UCC_CTL_OFFSET = 8'h08;

  // Command register field positions
  localparam int UCC_RUN_BIT = 0;
  localparam int UCC_RST_BIT = 1;
  localparam int UCC_FLS_LO = 2;
  localparam int UCC_PSE_BIT = 4;
  localparam int UCC_ASE_BIT = 5;
  localparam int UCC_DOOR_BIT = 6;
  localparam int UCC_LRST_BIT = 7;
  localparam int UCC_PARK_LO = 8;
  localparam int UCC_PARKEN_BIT = 11;
  localparam int UCC_RSVD_BIT = 10;
  localparam int UCC_FLS_HI = 15;

  // Status register field positions
  localparam int UCC_HALT_BIT = 12;
  localparam int UCC_AAS_BIT = 5;
  localparam int UCC_IRQ_BIT = 0;

  // Control register field positions
  localparam int UCC_DEVMODE_BIT = 0;
  localparam int UCC_AAIE_BIT = 1;
  localparam int UCC_PFLCAP_BIT = 2;
  localparam int UCC_HS_BIT = 3;

  // Reset values
  localparam logic [1:0] UCC_PARK_RESET = 2'h0;
  localparam logic [2:0] UCC_FLS_RESET = 3'h0;

  // Timing: controller reset sequence length and threshold interval
  localparam int UCC_CLK_MHZ = 40;
  localparam int UCC_RST_NS = 1000;
  localparam int UCC_RST_CYCLES = (UCC_RST_NS * UCC_CLK_MHZ + 999) / 1000;
  localparam int UCC_UFRAME_NS = 125000;
  localparam int UCC_UFRAME_CYCLES = (UCC_UFRAME_NS / 1000) * UCC_CLK_MHZ;

  // Frame list size encodings
  localparam logic [2:0] UCC_FLS_MAX_CODE = 3'h6;

  // Command fields as held by the block
  typedef struct packed {
    logic park_enable;
    logic [1:0] park_count;
    logic async_advance_doorbell;
    logic async_schedule_enable;
    logic periodic_schedule_enable;
    logic [2:0] frame_list_size;
    logic ctrl_reset;
    logic run_stop;
  } ucc_cmd_type;

  // Schedule side inputs from the traversal engine
  typedef struct packed {
    logic txn_busy;
    logic cache_flushed;
    logic error_stop;
  } ucc_sched_type;

endpackage

// [ucc_reset_seq.sv]
// Controller reset sequencer: holds a soft reset for a fixed cycle count
`timescale 1ns/1ps
`default_nettype none
module ucc_reset_seq
#(
  parameter int CYCLES = 40
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  import ucc_pkg::*;

  logic [15:0] count_reg; // Remaining cycles of the reset

  // Down counter; a start while busy is ignored so a reset cannot be cut
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 16'h0000;
    else if (start && count_reg == 16'h0000)
      count_reg <= 16'(CYCLES);
    else if (count_reg != 16'h0000)
      count_reg <= count_reg - 16'h0001;
  end

  assign busy = (count_reg != 16'h0000);
  assign done = (count_reg == 16'h0001);
endmodule
`default_nettype wire

// [ucc_threshold.sv]
// Interrupt threshold tick: one-cycle enable at each microframe boundary
`timescale 1ns/1ps
`default_nettype none
module ucc_threshold
#(
  parameter int PERIOD = 5000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  output logic tick
);
  import ucc_pkg::*;

  logic [15:0] div_reg; // Divider state

  // Free divider, restarted by the controller reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 16'h0000;
    else if (clr || div_reg == 16'(PERIOD - 1))
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  assign tick = (div_reg == 16'(PERIOD - 1));
endmodule
`default_nettype wire

// [ucc_top.sv]
// Command register control of a dual-role USB controller, APB slave
// How it works
// - Park count bits 9:8, reset zero
// - Light reset bit 7 reads zero
// - Doorbell sets async-advance status after flush
// - Enabled status raises interrupt at threshold
// - Doorbell clears only after status set
// - Async enable gates async schedule fetch
// - Periodic enable gates periodic schedule fetch
// - Frame size bits 15,3:2, writable if capable
// - Codes 0..6 give 1024 down to 16
// - Frame size picks frame index bits
// - Reset bit self-clears, zero cannot abort
// - Reset aborts transaction, no bus reset
// - Run/stop clear finishes transaction, then halts
// - Device run enables pull-up, attaches
// - Pull-up drops on high-speed entry
// - Device run clear detaches
// - Halted zero while host run (stays set in device mode), set after stop
// - Park enable bit 11, reset zero
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ucc_top
#(
  parameter int RST_CYCLES = ucc_pkg::UCC_RST_CYCLES,
  parameter int UFRAME_CYCLES = ucc_pkg::UCC_UFRAME_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_mode,
  input wire logic prog_frame_list_cap,
  input wire logic hs_entered,
  input wire ucc_pkg::ucc_sched_type sched_in,
  input wire logic [13:0] frame_index,
  output ucc_pkg::ucc_cmd_type cmd_out,
  output logic async_fetch_en,
  output logic periodic_fetch_en,
  output logic cache_flush_req,
  output logic txn_abort,
  output logic ctrl_soft_reset,
  output logic halted_status,
  output logic async_advance_status,
  output logic async_advance_irq,
  output logic dp_pullup_en,
  output logic [9:0] frame_list_index
);
  import ucc_pkg::*;

  // Host schedule state
  typedef enum logic [2:0]
  {
    ST_HALTED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_STOPPING = 3'b100
  } ucc_state_type;

  ucc_state_type state_reg; // Run/halt state
  ucc_state_type state_next; // Next run/halt state
  ucc_cmd_type cmd_reg; // Writable command fields
  logic aas_reg; // Async-advance status flag
  logic irq_reg; // Pending async-advance interrupt
  logic aaie_reg; // Async-advance interrupt enable
  logic pullup_reg; // D+ pull-up drive
  logic [2:0] sync_mode_reg; // Pin synchronisers: mode, capability, high-speed
  logic [2:0] mode_reg; // Synchronised copies
  logic rst_busy; // Soft reset in progress
  logic rst_done; // Last cycle of soft reset
  logic thr_tick; // Microframe threshold tick
  logic wr_en; // APB write strobe
  logic rd_en; // APB read strobe
  logic cmd_sel; // Command register selected
  logic sts_sel; // Status register selected
  logic ctl_sel; // Control register selected
  logic run_wr; // Run/stop written
  logic dev_m; // Device mode
  logic pfl_cap; // Programmable frame list capability
  logic hs_m; // High-speed entered
  logic [31:0] rd_data; // Read mux

  assign dev_m = mode_reg[0];
  assign pfl_cap = mode_reg[1];
  assign hs_m = mode_reg[2];

  // Two-stage synchronisers for pin-level inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_mode_reg <= 3'h0;
      mode_reg <= 3'h0;
    end
    else
    begin
      sync_mode_reg <= {hs_entered, prog_frame_list_cap, device_mode};
      mode_reg <= sync_mode_reg;
    end
  end

  // APB decode; zero wait states, unmapped offsets flag an error
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cmd_sel = (paddr == UCC_CMD_OFFSET);
  assign sts_sel = (paddr == UCC_STS_OFFSET);
  assign ctl_sel = (paddr == UCC_CTL_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(cmd_sel || sts_sel || ctl_sel);
  assign run_wr = wr_en && cmd_sel;

  // Soft reset timer: the sequence cannot be cut short by a zero write
  ucc_reset_seq #(.CYCLES(RST_CYCLES)) u_rst
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(cmd_reg.ctrl_reset && !rst_busy),
    .busy(rst_busy),
    .done(rst_done)
  );

  // Microframe boundary used as interrupt threshold
  ucc_threshold #(.PERIOD(UFRAME_CYCLES)) u_thr
  (
    .pclk(pclk),
    .presetn(presetn),
    .clr(rst_busy),
    .tick(thr_tick)
  );

  // Command register fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg <= '0;
      cmd_reg.park_count <= UCC_PARK_RESET;
      cmd_reg.frame_list_size <= UCC_FLS_RESET;
    end
    else if (rst_busy)
    begin
      // Reset returns fields to initial values; bit self-clears at the end
      cmd_reg <= '0;
      cmd_reg.ctrl_reset <= !rst_done;
    end
    else
    begin
      if (run_wr)
      begin
        cmd_reg.park_count <= pwdata[UCC_PARK_LO +: 2];
        cmd_reg.park_enable <= pwdata[UCC_PARKEN_BIT];
        cmd_reg.async_schedule_enable <= pwdata[UCC_ASE_BIT];
        cmd_reg.periodic_schedule_enable <= pwdata[UCC_PSE_BIT];
        cmd_reg.run_stop <= pwdata[UCC_RUN_BIT];
        if (pfl_cap)
          cmd_reg.frame_list_size <= {pwdata[UCC_FLS_HI], pwdata[UCC_FLS_LO +: 2]};
        if (pwdata[UCC_RST_BIT])
          cmd_reg.ctrl_reset <= 1'b1;
      end
      // Doorbell: a one rings; it is cleared only as the status sets
      if (run_wr && pwdata[UCC_DOOR_BIT])
        cmd_reg.async_advance_doorbell <= 1'b1;
      else if (cmd_reg.async_advance_doorbell && sched_in.cache_flushed)
        cmd_reg.async_advance_doorbell <= 1'b0;
      // Internal error stops the controller like a software clear
      if (sched_in.error_stop)
        cmd_reg.run_stop <= 1'b0;
    end
  end

  // Async-advance status: sticky, software clears by writing one; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      aas_reg <= 1'b0;
    else if (rst_busy)
      aas_reg <= 1'b0;
    else if (cmd_reg.async_advance_doorbell && sched_in.cache_flushed)
      aas_reg <= 1'b1;
    else if (wr_en && sts_sel && pwdata[UCC_AAS_BIT])
      aas_reg <= 1'b0;
  end

  // Interrupt raised at the next threshold boundary while enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else if (!aas_reg || !aaie_reg || rst_busy)
      irq_reg <= 1'b0;
    else if (thr_tick)
      irq_reg <= 1'b1;
  end

  // Interrupt enable held in the control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      aaie_reg <= 1'b0;
    else if (wr_en && ctl_sel)
      aaie_reg <= pwdata[UCC_AAIE_BIT];
  end

  // Host run/halt state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_HALTED:
        if (cmd_reg.run_stop && !dev_m && !rst_busy)
          state_next = ST_RUNNING;
      ST_RUNNING:
        if (rst_busy)
          state_next = ST_HALTED;
        else if (!cmd_reg.run_stop)
          state_next = ST_STOPPING;
      ST_STOPPING:
        // Finish the current transaction before halting
        if (rst_busy || !sched_in.txn_busy)
          state_next = ST_HALTED;
      default:
        state_next = ST_HALTED;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= ST_HALTED;
    else
      state_reg <= state_next;
  end

  // D+ pull-up: the run write itself decides, since run/stop lags it by a cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pullup_reg <= 1'b0;
    else if (!dev_m || rst_busy || hs_m)
      pullup_reg <= 1'b0;
    else if (run_wr)
      pullup_reg <= pwdata[UCC_RUN_BIT];
    else if (!cmd_reg.run_stop)
      pullup_reg <= 1'b0;
  end

  // Read mux; light reset bit 7 and reserved bit 10 stay zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (cmd_sel)
    begin
      rd_data[UCC_RUN_BIT] = cmd_reg.run_stop;
      rd_data[UCC_RST_BIT] = cmd_reg.ctrl_reset;
      rd_data[UCC_FLS_LO +: 2] = cmd_reg.frame_list_size[1:0];
      rd_data[UCC_FLS_HI] = cmd_reg.frame_list_size[2];
      rd_data[UCC_PSE_BIT] = cmd_reg.periodic_schedule_enable;
      rd_data[UCC_ASE_BIT] = cmd_reg.async_schedule_enable;
      rd_data[UCC_DOOR_BIT] = cmd_reg.async_advance_doorbell;
      rd_data[UCC_LRST_BIT] = 1'b0;
      rd_data[UCC_PARK_LO +: 2] = cmd_reg.park_count;
      rd_data[UCC_PARKEN_BIT] = cmd_reg.park_enable;
    end
    else if (sts_sel)
    begin
      rd_data[UCC_HALT_BIT] = (state_reg == ST_HALTED);
      rd_data[UCC_AAS_BIT] = aas_reg;
      rd_data[UCC_IRQ_BIT] = irq_reg;
    end
    else if (ctl_sel)
    begin
      rd_data[UCC_DEVMODE_BIT] = dev_m;
      rd_data[UCC_AAIE_BIT] = aaie_reg;
      rd_data[UCC_PFLCAP_BIT] = pfl_cap;
      rd_data[UCC_HS_BIT] = hs_m;
    end
  end

  // Registered read data, loaded in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_data;
  end

  // Frame list index: size code picks 10 down to 4 index bits
  always_comb
  begin
    frame_list_index = 10'h000;
    case (cmd_reg.frame_list_size)
      3'h0: frame_list_index = frame_index[12:3];
      3'h1: frame_list_index = {1'b0, frame_index[11:3]};
      3'h2: frame_list_index = {2'h0, frame_index[10:3]};
      3'h3: frame_list_index = {3'h0, frame_index[9:3]};
      3'h4: frame_list_index = {4'h0, frame_index[8:3]};
      3'h5: frame_list_index = {5'h00, frame_index[7:3]};
      UCC_FLS_MAX_CODE: frame_list_index = {6'h00, frame_index[6:3]};
      default: frame_list_index = frame_index[12:3];
    endcase
  end

  // Outputs toward the schedule engine and PHY
  assign cmd_out = cmd_reg;
  assign async_fetch_en = !dev_m && state_reg == ST_RUNNING
    && cmd_reg.async_schedule_enable;
  assign periodic_fetch_en = !dev_m && state_reg == ST_RUNNING
    && cmd_reg.periodic_schedule_enable;
  assign cache_flush_req = cmd_reg.async_advance_doorbell && !aas_reg;
  assign txn_abort = rst_busy;
  assign ctrl_soft_reset = rst_busy;
  assign halted_status = (state_reg == ST_HALTED);
  assign async_advance_status = aas_reg;
  assign async_advance_irq = irq_reg;
  assign dp_pullup_en = pullup_reg;

  // Checks
  halt_vs_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_reg.run_stop && !dev_m && !rst_busy && state_reg != ST_STOPPING |=> !halted_status)
    else $error("halted while running");
  door_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cmd_reg.async_advance_doorbell) && !rst_busy |-> aas_reg)
    else $error("doorbell cleared before status");
  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_reg.async_advance_doorbell && sched_in.cache_flushed && !rst_busy
    |=> aas_reg)
    else $error("status not set after flush");
  lr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && cmd_sel |-> !prdata[UCC_LRST_BIT] && !prdata[UCC_RSVD_BIT])
    else $error("reserved bit reads one");
  pullup_hs_a: assert property (@(posedge pclk) disable iff (!presetn)
    hs_m |=> !dp_pullup_en)
    else $error("pull-up on in high speed");
  stop_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_STOPPING && sched_in.txn_busy && !rst_busy |=> !halted_status)
    else $error("halted mid transaction");
  reset_self_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_done |=> !cmd_reg.ctrl_reset)
    else $error("reset bit not cleared");
  fetch_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cmd_reg.async_schedule_enable |-> !async_fetch_en)
    else $error("async fetch while disabled");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    aas_reg && aaie_reg && thr_tick && !rst_busy |=> async_advance_irq)
    else $error("interrupt missed threshold");

  run_cov: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_STOPPING ##1 state_reg == ST_HALTED);
  door_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(aas_reg));
  attach_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(dp_pullup_en));
  rst_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(rst_busy));
endmodule
`default_nettype wire

// [ucc_peer_model.sv]
// Peer model: schedule engine and bus activity seen by the command block
`timescale 1ns/1ps
`default_nettype none
module ucc_peer_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cache_flush_req,
  input wire logic txn_abort,
  input wire logic fetch_en,
  input wire logic [3:0] flush_dly,
  input wire logic [3:0] txn_len,
  output ucc_pkg::ucc_sched_type sched_in
);
  import ucc_pkg::*;
  // Cycles left in the cache flush and in the bus transaction
  logic [3:0] flush_cnt_reg;
  logic [3:0] txn_cnt_reg;
  // Flush ends flush_dly cycles after the request rises; zero answers at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flush_cnt_reg <= 4'h0;
    else if (!cache_flush_req)
      flush_cnt_reg <= flush_dly;
    else if (flush_cnt_reg != 4'h0)
      flush_cnt_reg <= flush_cnt_reg - 4'h1;
  end
  // Transaction runs txn_len cycles past the last fetch, so a stop waits for it unless txn_len is zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txn_cnt_reg <= 4'h0;
    else if (txn_abort)
      txn_cnt_reg <= 4'h0;
    else if (fetch_en)
      txn_cnt_reg <= txn_len;
    else if (txn_cnt_reg != 4'h0)
      txn_cnt_reg <= txn_cnt_reg - 4'h1;
  end
  // Flush completion is a level held while the request stands
  assign sched_in.cache_flushed = cache_flush_req && (flush_cnt_reg == 4'h0);
  assign sched_in.txn_busy = (txn_cnt_reg != 4'h0);
  // This peer never reports an internal fault
  assign sched_in.error_stop = 1'b0;
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the command register control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ucc_pkg::*;
  // Bus, pin and peer signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic device_mode, cap, hs, abort, soft_rst, halted, aas, irq, pull, flush_req, afe, pfe;
  logic [13:0] fidx;
  logic [9:0] fli;
  logic [3:0] flush_dly, txn_len;
  ucc_sched_type sched;
  ucc_cmd_type cmd;
  int n_fail, num_checks;
  // Rows: value written to the command register, value read back
  logic [31:0] rows [4][2];
  // Short counts keep the run brief
  ucc_top #(.RST_CYCLES(16), .UFRAME_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_mode(device_mode),
    .prog_frame_list_cap(cap), .hs_entered(hs), .sched_in(sched), .frame_index(fidx),
    .cmd_out(cmd), .async_fetch_en(afe), .periodic_fetch_en(pfe),
    .cache_flush_req(flush_req), .txn_abort(abort), .ctrl_soft_reset(soft_rst),
    .halted_status(halted), .async_advance_status(aas), .async_advance_irq(irq),
    .dp_pullup_en(pull), .frame_list_index(fli));
  ucc_peer_model u_peer (.pclk(pclk), .presetn(presetn), .cache_flush_req(flush_req),
    .txn_abort(abort), .fetch_en(afe | pfe), .flush_dly(flush_dly), .txn_len(txn_len),
    .sched_in(sched));
  // Prints the counts and the verdict, then ends the run
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
  endtask
  // Reads until the masked field matches, under a bound
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      k++;
    end
    while ((rd & m) !== v && k < 40);
    chk(rd & m, v);
    if ((rd & m) !== v)
      give_verdict();
  endtask
  // Free-running bus clock, 25 ns period
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    int k;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {device_mode, hs} = 2'h0;
    cap = 1'b1;
    fidx = 14'h2b5d;
    flush_dly = 4'h5;
    txn_len = 4'hc;
    n_fail = 0;
    num_checks = 0;
    rows = '{'{32'h0000_0b00, 32'h0000_0b00}, '{32'h0000_0780, 32'h0000_0300},
      '{32'h0000_8030, 32'h0000_8030}, '{32'h0000_000c, 32'h0000_000c}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, UCC_CMD_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, UCC_STS_OFFSET, 32'h0);
    chk(rd & 32'h1000, 32'h1000);
    // Field writes; park count three or zero
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, UCC_CMD_OFFSET, rows[i][0]);
      apb(1'b0, UCC_CMD_OFFSET, 32'h0);
      chk(rd, rows[i][1]);
    end
    // Every frame list size code picks its slice of the frame index
    for (int c = 0; c < 7; c++)
    begin
      apb(1'b1, UCC_CMD_OFFSET, {16'h0, c[2], 11'h0, c[1:0], 2'h0});
      @(negedge pclk);
      chk(32'(fli), 32'(fidx[12:3]) & ((32'h400 >> c) - 1));
    end
    // Without the capability the size field holds
    cap <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0000_0004);
    apb(1'b0, UCC_CMD_OFFSET, 32'h0);
    chk(rd, 32'h0000_8008);
    // Unmapped address is refused
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Host run, then stop while a transaction is still on the bus
    apb(1'b1, UCC_CMD_OFFSET, 32'h0000_0021);
    repeat (2) @(negedge pclk);
    chk({29'h0, halted, afe, pfe}, 32'h2);
    apb(1'b0, UCC_STS_OFFSET, 32'h0);
    chk(rd & 32'h1000, 32'h0);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0000_0020);
    apb(1'b0, UCC_STS_OFFSET, 32'h0);
    chk(rd & 32'h1000, 32'h0);
    poll(UCC_STS_OFFSET, 32'h1000, 32'h1000);
    // Doorbell with the async schedule running and its interrupt enabled
    apb(1'b1, UCC_CTL_OFFSET, 32'h2);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0000_0021);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0000_0061);
    @(negedge pclk);
    chk({30'h0, aas, cmd.async_advance_doorbell}, 32'h1);
    poll(UCC_STS_OFFSET, 32'h20, 32'h20);
    apb(1'b0, UCC_CMD_OFFSET, 32'h0);
    chk(rd & 32'h40, 32'h0);
    for (k = 0; k < 60 && irq !== 1'b1; k++)
      @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, UCC_STS_OFFSET, 32'h20);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0);
    poll(UCC_STS_OFFSET, 32'h1000, 32'h1000);
    // Controller reset issued while halted; a zero write must not cut it short
    apb(1'b1, UCC_CMD_OFFSET, 32'h0000_0b32);
    repeat (2) @(negedge pclk);
    chk({30'h0, soft_rst, abort}, 32'h3);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0);
    apb(1'b0, UCC_CMD_OFFSET, 32'h0);
    chk(rd & 32'h2, 32'h2);
    poll(UCC_CMD_OFFSET, 32'hffff_ffff, 32'h0);
    // Device mode attach, detach, and high-speed entry
    device_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, UCC_CMD_OFFSET, 32'h1);
    repeat (4) @(negedge pclk);
    chk({31'h0, pull}, 32'h1);
    apb(1'b1, UCC_CMD_OFFSET, 32'h0);
    repeat (4) @(negedge pclk);
    chk({31'h0, pull}, 32'h0);
    apb(1'b1, UCC_CMD_OFFSET, 32'h1);
    hs <= 1'b1;
    repeat (6) @(negedge pclk);
    chk({30'h0, cmd.run_stop, pull}, 32'h2);
    give_verdict();
  end
endmodule
`default_nettype wire
